/* inc/wdt_map.svh */
/*
 * Register offsets, field positions, reset values and the unlock key
 * of the watchdog timer block.
 * Assumes an 8-bit byte address on the AXI4-Lite register port.
 */
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// Byte offsets, one aligned 32-bit word each
`define WDT_OFS_LOAD   8'h00
`define WDT_OFS_VALUE  8'h04
`define WDT_OFS_CTRL   8'h08
`define WDT_OFS_ICR    8'h0C
`define WDT_OFS_RIS    8'h10
`define WDT_OFS_MIS    8'h14
`define WDT_OFS_LOCK   8'h18

// Control register fields
`define WDT_CTL_CNT_EN 0
`define WDT_CTL_INT_EN 1
`define WDT_CTL_RST_EN 2
`define WDT_CTL_NMI    3
`define WDT_CTL_STALL  4

// Reset values
`define WDT_LOAD_RST   32'hFFFF_FFFF
// Unlock key, value is arbitrary
`define WDT_UNLOCK_KEY 32'h5A5A_0F0F

// AXI responses
`define WDT_RESP_OKAY   2'h0
`define WDT_RESP_SLVERR 2'h2

`endif

/* inc/wdt_pkg.sv */
/*
 * Types shared by the watchdog timer modules.
 * Assumes the constants of wdt_map.svh.
 */
package wdt_pkg;
    typedef logic [31:0] wdt_word_t;
    typedef logic [7:0]  wdt_addr_t;
    typedef logic [1:0]  wdt_resp_t;

    // Life cycle of the counter
    typedef enum logic [1:0] {
        WDT_PH_OFF   = 2'b00,
        WDT_PH_COUNT = 2'b01,
        WDT_PH_RESET = 2'b10
    } wdt_phase_t;
endpackage

/* inc/wdt_reg_if.sv */
/*
 * Register access path between the AXI4-Lite front end and the core.
 * Assumes one write strobe per cycle and a combinational read mux.
 */
`timescale 1ns/100ps
`default_nettype none
interface wdt_reg_if;
    logic                     wr_en;
    wdt_pkg::wdt_addr_t       wr_addr;
    wdt_pkg::wdt_word_t       wr_data;
    logic [3:0]               wr_strb;
    logic                     wr_ok;
    wdt_pkg::wdt_addr_t       rd_addr;
    wdt_pkg::wdt_word_t       rd_data;
    logic                     rd_ok;

    modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input wr_ok, rd_data, rd_ok);
    modport core  (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output wr_ok, rd_data, rd_ok);
endinterface
`default_nettype wire

/* rtl/wdt_axil.sv */
/*
 * AXI4-Lite slave front end of the watchdog timer.
 * Assumes the core answers decode and read data combinationally.
 */
`timescale 1ns/100ps
`default_nettype none
`include "wdt_map.svh"
module wdt_axil (
    // Clock and reset
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // Write address and data
    input  wire wdt_pkg::wdt_addr_t awaddr,
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire wdt_pkg::wdt_word_t wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output logic                    wready,
    // Write response
    output wdt_pkg::wdt_resp_t      bresp,
    output logic                    bvalid,
    input  wire logic               bready,
    // Read address and data
    input  wire wdt_pkg::wdt_addr_t araddr,
    input  wire logic               arvalid,
    output logic                    arready,
    output wdt_pkg::wdt_word_t      rdata,
    output wdt_pkg::wdt_resp_t      rresp,
    output logic                    rvalid,
    input  wire logic               rready,
    // Core side
    wdt_reg_if.slave                rif
);
    import wdt_pkg::*;

    wdt_addr_t awaddr_q;
    wdt_word_t wdata_q;
    logic [3:0] wstrb_q;

    // A low ready means the item is held; the write fires once both are held
    assign rif.wr_en   = !awready && !wready && !bvalid;
    assign rif.wr_addr = awaddr_q;
    assign rif.wr_data = wdata_q;
    assign rif.wr_strb = wstrb_q;
    assign rif.rd_addr = araddr;

    // Write address channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready  <= 1'b1;
            awaddr_q <= 8'h00;
        end else if (awvalid && awready) begin
            awready  <= 1'b0;
            awaddr_q <= awaddr;
        end else if (bvalid && bready) begin
            awready  <= 1'b1;
        end
    end

    // Write data channel, taken independently of the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready  <= 1'b1;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (wvalid && wready) begin
            wready  <= 1'b0;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
        end else if (bvalid && bready) begin
            wready  <= 1'b1;
        end
    end

    // Write response, one cycle after the write strobe
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= `WDT_RESP_OKAY;
        end else if (rif.wr_en) begin
            bvalid <= 1'b1;
            bresp  <= rif.wr_ok ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read channel; data is sampled at the address handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `WDT_RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rif.rd_data;
            rresp   <= rif.rd_ok ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* rtl/wdt_top.sv */
/*
 * Watchdog timer: 32-bit down counter with load register, interrupt,
 * second-timeout reset request and configuration lock.
 * Assumes one 40 MHz clock, a synchronous active-low reset, and a debug
 * halt level arriving asynchronously from the processor.
 */
// Implementation choices: the AXI4-Lite register port and the register addresses.
// What this block does
// R1: Timeout counter is a 32-bit down counter starting from a loadable value.
// R2: While locked, writes to configuration registers are ignored.
// R3: While locked, enable, interrupt enable and load value writes do nothing.
// R4: Enabled counter reaching zero marks first timeout and sets interrupt status.
// R5: Enabling the counter enables the interrupt; a separate interrupt enable exists.
// R6: After first timeout the counter reloads from the load register and counts on.
// R7: Second zero with status still set and reset enabled asserts system reset.
// R8: Clearing the interrupt before second timeout reloads the counter, no reset.
// R9: New load value written while running loads the counter at once.
// R10: Interrupt clear deasserts the interrupt source, possibly a few cycles late.
// R11: Software reads raw status and masked status, raw gated by interrupt enable.
// R12: A status bit of one means interrupt active, zero means inactive.
// R13: Interrupt type selects standard interrupt by default or non-maskable.
// R14: In non-maskable mode the enable still gates and software still clears.
// R15: Lock indication reads true while locked, false while unlocked.
// R16: Programmed load value reads back.
// R17: Reset enable decides whether second timeout resets; otherwise only interrupts.
// R18: Writing a load value of zero raises the interrupt immediately.
// R19: With stall enabled the counter holds while the debugger halts the processor.
// R20: Software reads whether the counter is enabled and its present value.
// R21: Counter stays enabled and reset request stays asserted until system reset.
`timescale 1ns/100ps
`default_nettype none
`include "wdt_map.svh"
module wdt_top (
    // Clock and reset
    input  wire logic               aclk,
    input  wire logic               aresetn,
    // Write address and data
    input  wire wdt_pkg::wdt_addr_t awaddr,
    input  wire logic               awvalid,
    output logic                    awready,
    input  wire wdt_pkg::wdt_word_t wdata,
    input  wire logic [3:0]         wstrb,
    input  wire logic               wvalid,
    output logic                    wready,
    // Write response
    output wdt_pkg::wdt_resp_t      bresp,
    output logic                    bvalid,
    input  wire logic               bready,
    // Read address and data
    input  wire wdt_pkg::wdt_addr_t araddr,
    input  wire logic               arvalid,
    output logic                    arready,
    output wdt_pkg::wdt_word_t      rdata,
    output wdt_pkg::wdt_resp_t      rresp,
    output logic                    rvalid,
    input  wire logic               rready,
    // Processor side
    input  wire logic               dbg_halted,
    output logic                    wdt_irq,
    output logic                    wdt_nmi,
    output logic                    sys_reset_req
);
    import wdt_pkg::*;

    wdt_reg_if rif ();

    wdt_word_t  load_val;
    wdt_word_t  count;
    wdt_word_t  next_load;
    wdt_phase_t phase;
    logic       int_en;
    logic       rst_en;
    logic       nmi_sel;
    logic       stall_en;
    logic       locked;
    logic       ris;
    logic       halt_meta;
    logic       halt_sync;
    logic       running;
    logic       cfg_ok;
    logic       wr_load;
    logic       wr_ctrl;
    logic       wr_icr;
    logic       wr_lock;
    logic       tick;
    logic       timeout;
    logic       zero_load;
    logic       masked;

    wdt_axil u_bus (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .rif     (rif.slave)
    );

    // Debug halt comes from another domain; two flops before use
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            halt_meta <= 1'b0;
            halt_sync <= 1'b0;
        end else begin
            halt_meta <= dbg_halted;
            halt_sync <= halt_meta;
        end
    end

    // Write decode; config writes need the lock open
    assign cfg_ok  = !locked;                                              // R2
    assign wr_load = rif.wr_en && rif.wr_addr == `WDT_OFS_LOAD && cfg_ok;  // R3
    assign wr_ctrl = rif.wr_en && rif.wr_addr == `WDT_OFS_CTRL && cfg_ok;  // R3
    assign wr_icr  = rif.wr_en && rif.wr_addr == `WDT_OFS_ICR;
    assign wr_lock = rif.wr_en && rif.wr_addr == `WDT_OFS_LOCK;

    // Byte lanes merge into the old load value
    always_comb begin
        next_load = load_val;
        for (int i = 0; i < 4; i++) begin
            if (rif.wr_strb[i]) begin
                next_load[8*i +: 8] = rif.wr_data[8*i +: 8];
            end
        end
    end

    // Counter advances unless held by the debugger
    assign running   = phase != WDT_PH_OFF;
    assign tick      = running && !(stall_en && halt_sync);               // R19
    assign timeout   = tick && count == 32'h0000_0000 && !wr_load && !wr_icr;
    assign zero_load = wr_load && next_load == 32'h0000_0000;            // R18
    assign masked    = ris && int_en;                                     // R11

    // Load register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            load_val <= `WDT_LOAD_RST;
        end else if (wr_load) begin
            load_val <= next_load;                                        // R16
        end
    end

    // Down counter; a live load write or a clear outranks the decrement
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= `WDT_LOAD_RST;
        end else if (!running) begin
            count <= wr_load ? next_load : load_val;
        end else if (wr_load) begin
            count <= next_load;                                           // R9
        end else if (wr_icr) begin
            count <= load_val;                                            // R8
        end else if (timeout) begin
            count <= load_val;                                            // R6
        end else if (tick) begin
            count <= count - 32'h0000_0001;                               // R1
        end
    end

    // Phase: off until enabled, then only a system reset stops it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase <= WDT_PH_OFF;
        end else begin
            unique case (phase)
                WDT_PH_OFF: begin
                    if (wr_ctrl && rif.wr_data[`WDT_CTL_CNT_EN]) begin
                        phase <= WDT_PH_COUNT;
                    end
                end
                WDT_PH_COUNT: begin
                    if (timeout && ris && rst_en) begin
                        phase <= WDT_PH_RESET;                            // R7
                    end
                end
                WDT_PH_RESET: begin
                    phase <= WDT_PH_RESET;                                // R21
                end
                default: begin
                    phase <= WDT_PH_OFF;
                end
            endcase
        end
    end

    // Control bits; the interrupt enable can only be set, never withdrawn; the other bits follow each write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_en   <= 1'b0;
            rst_en   <= 1'b0;
            nmi_sel  <= 1'b0;                                             // R13
            stall_en <= 1'b0;
        end else if (wr_ctrl) begin
            int_en   <= int_en | rif.wr_data[`WDT_CTL_INT_EN] | rif.wr_data[`WDT_CTL_CNT_EN]; // R5
            rst_en   <= rif.wr_data[`WDT_CTL_RST_EN];                     // R17
            nmi_sel  <= rif.wr_data[`WDT_CTL_NMI];
            stall_en <= rif.wr_data[`WDT_CTL_STALL];
        end
    end

    // Lock: the key opens it, any other value closes it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            locked <= 1'b0;
        end else if (wr_lock) begin
            locked <= rif.wr_data != `WDT_UNLOCK_KEY;
        end
    end

    // Raw status; a clear in the cycle the count reaches zero suppresses that timeout
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ris <= 1'b0;
        end else if (timeout || zero_load) begin
            ris <= 1'b1;                                                  // R4
        end else if (wr_icr) begin
            ris <= 1'b0;                                                  // R10
        end
    end

    // Interrupt lines; the enable gates both types
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdt_irq <= 1'b0;
            wdt_nmi <= 1'b0;
        end else begin
            wdt_irq <= masked && !nmi_sel;
            wdt_nmi <= masked && nmi_sel;                                 // R14
        end
    end

    // Reset request holds until the system reset lands
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sys_reset_req <= 1'b0;
        end else if (timeout && ris && rst_en) begin
            sys_reset_req <= 1'b1;                                        // R7
        end
    end

    // Register decode and read mux; status bits read one when active
    always_comb begin
        rif.rd_ok   = 1'b1;
        rif.rd_data = 32'h0000_0000;
        unique case (rif.rd_addr)
            `WDT_OFS_LOAD:  rif.rd_data = load_val;                       // R16
            `WDT_OFS_VALUE: rif.rd_data = count;                          // R20
            `WDT_OFS_CTRL: begin
                rif.rd_data[`WDT_CTL_CNT_EN] = running;                   // R20
                rif.rd_data[`WDT_CTL_INT_EN] = int_en;
                rif.rd_data[`WDT_CTL_RST_EN] = rst_en;
                rif.rd_data[`WDT_CTL_NMI]    = nmi_sel;
                rif.rd_data[`WDT_CTL_STALL]  = stall_en;
            end
            `WDT_OFS_ICR:   rif.rd_data = 32'h0000_0000;
            `WDT_OFS_RIS:   rif.rd_data[0] = ris;                         // R12
            `WDT_OFS_MIS:   rif.rd_data[0] = masked;                      // R11
            `WDT_OFS_LOCK:  rif.rd_data[0] = locked;                      // R15
            default:        rif.rd_ok = 1'b0;
        endcase
    end

    // Writes to read-only words are accepted and dropped
    always_comb begin
        unique case (rif.wr_addr)
            `WDT_OFS_LOAD, `WDT_OFS_VALUE, `WDT_OFS_CTRL, `WDT_OFS_ICR,
            `WDT_OFS_RIS, `WDT_OFS_MIS, `WDT_OFS_LOCK: rif.wr_ok = 1'b1;
            default: rif.wr_ok = 1'b0;
        endcase
    end

    // Checks on the core behaviour
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_count_down;
        tick && count != 32'h0000_0000 && !wr_load && !wr_icr |=> count == $past(count) - 32'h0000_0001;
    endproperty
    a_count_down: assert property (p_count_down) else $error("counter did not decrement"); // R1

    property p_lock_load;
        rif.wr_en && rif.wr_addr == `WDT_OFS_LOAD && locked |=> $stable(load_val);
    endproperty
    a_lock_load: assert property (p_lock_load) else $error("locked load write took effect"); // R2

    property p_lock_enable;
        !running && locked && rif.wr_en && rif.wr_addr == `WDT_OFS_CTRL |=> !running;
    endproperty
    a_lock_enable: assert property (p_lock_enable) else $error("locked enable write started counter"); // R3

    property p_first;
        timeout |=> ris ##1 (wdt_irq || wdt_nmi || !$past(int_en));
    endproperty
    a_first: assert property (p_first) else $error("timeout did not raise status"); // R4

    property p_enable;
        wr_ctrl && rif.wr_data[`WDT_CTL_CNT_EN] |=> running && int_en;
    endproperty
    a_enable: assert property (p_enable) else $error("enable did not start counter and interrupt"); // R5

    property p_reload;
        timeout |=> count == $past(load_val);
    endproperty
    a_reload: assert property (p_reload) else $error("no reload after timeout"); // R6

    property p_reset;
        timeout && ris && rst_en |=> sys_reset_req [*3];
    endproperty
    a_reset: assert property (p_reset) else $error("second timeout gave no reset"); // R7

    property p_no_reset;
        !rst_en && !sys_reset_req |=> !sys_reset_req;
    endproperty
    a_no_reset: assert property (p_no_reset) else $error("reset without reset enable"); // R17

    property p_clear;
        wr_icr && !timeout && !zero_load |=> !ris ##1 !wdt_irq && !wdt_nmi;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not drop interrupt"); // R10

    property p_type;
        masked && nmi_sel |=> wdt_nmi && !wdt_irq;
    endproperty
    a_type: assert property (p_type) else $error("non-maskable route wrong"); // R13

    property p_zero;
        zero_load |=> ris;
    endproperty
    a_zero: assert property (p_zero) else $error("zero load raised no interrupt"); // R18

    property p_stall;
        running && stall_en && halt_sync && !wr_load && !wr_icr |=> $stable(count);
    endproperty
    a_stall: assert property (p_stall) else $error("counter moved while stalled"); // R19

    property p_sticky;
        running |=> running;
    endproperty
    a_sticky: assert property (p_sticky) else $error("counter stopped before reset"); // R21

    c_timeout: cover property (timeout && !ris);
    c_reset:   cover property (sys_reset_req && !$past(sys_reset_req));
    c_nmi:     cover property (wdt_nmi);
    c_locked:  cover property (locked && rif.wr_en && rif.wr_addr == `WDT_OFS_LOAD);
endmodule
`default_nettype wire

/* sim/wdt_top_tb_top.sv */
/*
 * Self-checking bench for the watchdog timer top: register table, lock,
 * timeouts, reset request, interrupt type, zero load and debug stall.
 * Assumes the offsets of wdt_map.svh and an AXI4-Lite slave that answers in its own time.
 */
`timescale 1ns/100ps
`default_nettype none
`include "wdt_map.svh"
module wdt_top_tb_top;
    import wdt_pkg::*;
    typedef struct {logic wr; wdt_addr_t a; wdt_word_t d; wdt_resp_t r;} wdt_row_t;

    // Design ports
    logic       aclk = 1'b0;
    logic       aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic       arvalid, arready, rvalid, rready, dbg_halted, wdt_irq, wdt_nmi, sys_reset_req;
    logic [3:0] wstrb;
    wdt_addr_t  awaddr, araddr;
    wdt_word_t  wdata, rdata, d, v;
    wdt_resp_t  bresp, rresp, r;
    int         mismatches = 0;
    int         num_checks = 0;
    int         i;

    wdt_top i_wdt_top (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .dbg_halted(dbg_halted),
        .wdt_irq(wdt_irq), .wdt_nmi(wdt_nmi), .sys_reset_req(sys_reset_req)
    );

    // 40 MHz clock
    always #12.5 aclk = ~aclk;

    // Reads carry expected data and response; writes carry write data and expected response
    wdt_row_t rows [23] = '{
        '{1'b0, `WDT_OFS_LOAD,  32'hFFFF_FFFF, `WDT_RESP_OKAY},
        '{1'b0, `WDT_OFS_VALUE, 32'hFFFF_FFFF, `WDT_RESP_OKAY},
        '{1'b0, `WDT_OFS_CTRL,  32'h0000_0000, `WDT_RESP_OKAY},
        '{1'b0, `WDT_OFS_ICR,   32'h0000_0000, `WDT_RESP_OKAY},
        '{1'b0, `WDT_OFS_RIS,   32'h0000_0000, `WDT_RESP_OKAY},
        '{1'b0, `WDT_OFS_MIS,   32'h0000_0000, `WDT_RESP_OKAY},
        '{1'b0, `WDT_OFS_LOCK,  32'h0000_0000, `WDT_RESP_OKAY},
        '{1'b0, 8'h1C,          32'h0000_0000, `WDT_RESP_SLVERR},
        '{1'b1, 8'h1C,          32'h0000_0001, `WDT_RESP_SLVERR},
        '{1'b1, `WDT_OFS_LOAD,  32'h0000_0100, `WDT_RESP_OKAY},
        '{1'b0, `WDT_OFS_LOAD,  32'h0000_0100, `WDT_RESP_OKAY},
        '{1'b1, `WDT_OFS_CTRL,  32'h0000_001C, `WDT_RESP_OKAY},
        '{1'b0, `WDT_OFS_CTRL,  32'h0000_001C, `WDT_RESP_OKAY},
        '{1'b1, `WDT_OFS_CTRL,  32'h0000_0000, `WDT_RESP_OKAY},
        '{1'b0, `WDT_OFS_CTRL,  32'h0000_0000, `WDT_RESP_OKAY},
        '{1'b1, `WDT_OFS_LOCK,  32'h0000_0001, `WDT_RESP_OKAY},
        '{1'b0, `WDT_OFS_LOCK,  32'h0000_0001, `WDT_RESP_OKAY},
        '{1'b1, `WDT_OFS_LOAD,  32'h0000_0055, `WDT_RESP_OKAY},
        '{1'b1, `WDT_OFS_CTRL,  32'h0000_0003, `WDT_RESP_OKAY},
        '{1'b0, `WDT_OFS_LOAD,  32'h0000_0100, `WDT_RESP_OKAY},
        '{1'b0, `WDT_OFS_CTRL,  32'h0000_0000, `WDT_RESP_OKAY},
        '{1'b1, `WDT_OFS_LOCK,  `WDT_UNLOCK_KEY, `WDT_RESP_OKAY},
        '{1'b0, `WDT_OFS_LOCK,  32'h0000_0000, `WDT_RESP_OKAY}
    };

    task automatic chk(input string nm, input wdt_word_t x, input wdt_word_t g);
        num_checks++;
        if (g !== x) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
        end
    endtask

    // Both channels offered together, each released when taken
    task automatic bus_wr(input wdt_addr_t a, input wdt_word_t dw, output wdt_resp_t rs);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= dw;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic bus_rd(input wdt_addr_t a, output wdt_word_t dr, output wdt_resp_t rs);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        dr = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    task automatic rdc(input string nm, input wdt_addr_t a, input wdt_word_t x);
        wdt_word_t dr;
        wdt_resp_t rs;
        bus_rd(a, dr, rs);
        chk(nm, x, dr);
    endtask

    // Synchronous reset held for 12 cycles
    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Cuts a hang short; the whole run needs under a thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        stop_test();
    end

    initial begin
        {awvalid, wvalid, bready, arvalid, rready, dbg_halted} <= 6'h00;
        {awaddr, araddr, wdata, wstrb} <= {8'h00, 8'h00, 32'h0000_0000, 4'hF};
        do_reset();
        chk("outputs_after_reset", 32'h0000_0000, wdt_word_t'({wdt_irq, wdt_nmi, sys_reset_req}));
        for (i = 0; i < 23; i++) begin
            if (rows[i].wr) begin
                bus_wr(rows[i].a, rows[i].d, r);
            end else begin
                bus_rd(rows[i].a, d, r);
                chk($sformatf("rd_data_%0d", i), rows[i].d, d);
            end
            chk($sformatf("resp_%0d", i), wdt_word_t'(rows[i].r), wdt_word_t'(r));
        end
        // First timeout, reload, clear
        bus_wr(`WDT_OFS_LOAD, 32'h0000_0028, r);
        bus_wr(`WDT_OFS_CTRL, 32'h0000_0001, r);
        rdc("ctrl_enabled", `WDT_OFS_CTRL, 32'h0000_0003);
        bus_rd(`WDT_OFS_VALUE, d, r);
        chk("value_counting", 32'h0000_0001, wdt_word_t'(d < 32'h0000_0028));
        for (i = 0; i < 100 && wdt_irq !== 1'b1; i++) @(posedge aclk);
        chk("irq_first", 32'h0000_0001, wdt_word_t'({wdt_nmi, wdt_irq}));
        rdc("ris_set", `WDT_OFS_RIS, 32'h0000_0001);
        rdc("mis_set", `WDT_OFS_MIS, 32'h0000_0001);
        bus_rd(`WDT_OFS_VALUE, d, r);
        chk("value_reload", 32'h0000_0001, wdt_word_t'(d <= 32'h0000_0028 && d > 32'h0000_0014));
        bus_wr(`WDT_OFS_ICR, 32'h0000_0001, r);
        rdc("ris_clear", `WDT_OFS_RIS, 32'h0000_0000);
        chk("irq_clear", 32'h0000_0000, wdt_word_t'(wdt_irq));
        // Second timeout without and then with reset enable
        for (i = 0; i < 100 && wdt_irq !== 1'b1; i++) @(posedge aclk);
        repeat (60) @(posedge aclk);
        chk("no_reset_disabled", 32'h0000_0000, wdt_word_t'(sys_reset_req));
        rdc("ris_kept", `WDT_OFS_RIS, 32'h0000_0001);
        bus_wr(`WDT_OFS_CTRL, 32'h0000_0004, r);
        for (i = 0; i < 100 && sys_reset_req !== 1'b1; i++) @(posedge aclk);
        repeat (20) @(posedge aclk);
        chk("reset_request", 32'h0000_0001, wdt_word_t'(sys_reset_req));
        rdc("ctrl_sticky", `WDT_OFS_CTRL, 32'h0000_0007);
        do_reset();
        chk("reset_cleared", 32'h0000_0000, wdt_word_t'(sys_reset_req));
        // Zero load with non-maskable type, gated by the enable
        bus_wr(`WDT_OFS_CTRL, 32'h0000_0008, r);
        bus_wr(`WDT_OFS_LOAD, 32'h0000_0000, r);
        rdc("ris_zero_load", `WDT_OFS_RIS, 32'h0000_0001);
        rdc("mis_gated", `WDT_OFS_MIS, 32'h0000_0000);
        bus_wr(`WDT_OFS_CTRL, 32'h0000_000A, r);
        repeat (3) @(posedge aclk);
        chk("nmi_routed", 32'h0000_0002, wdt_word_t'({wdt_nmi, wdt_irq}));
        bus_wr(`WDT_OFS_ICR, 32'h0000_0001, r);
        repeat (4) @(posedge aclk);
        chk("nmi_cleared", 32'h0000_0000, wdt_word_t'({wdt_nmi, wdt_irq}));
        // Debug stall, then a load while running
        bus_wr(`WDT_OFS_LOAD, 32'h0000_03E8, r);
        bus_wr(`WDT_OFS_CTRL, 32'h0000_0011, r);
        dbg_halted <= 1'b1;
        repeat (4) @(posedge aclk);
        bus_rd(`WDT_OFS_VALUE, v, r);
        repeat (10) @(posedge aclk);
        rdc("value_stalled", `WDT_OFS_VALUE, v);
        dbg_halted <= 1'b0;
        repeat (4) @(posedge aclk);
        bus_rd(`WDT_OFS_VALUE, d, r);
        chk("value_resumed", 32'h0000_0001, wdt_word_t'(d < v));
        bus_wr(`WDT_OFS_LOAD, 32'h0000_0200, r);
        bus_rd(`WDT_OFS_VALUE, d, r);
        chk("value_new_load", 32'h0000_0001, wdt_word_t'(d <= 32'h0000_0200 && d > 32'h0000_01F0));
        // Only lane 0 may land in the load word
        wstrb <= 4'h1;
        bus_wr(`WDT_OFS_LOAD, 32'hFFFF_FFAA, r);
        wstrb <= 4'hF;
        rdc("load_byte_lane", `WDT_OFS_LOAD, 32'h0000_02AA);
        stop_test();
    end
endmodule
`default_nettype wire
